// File: adsr_consts.vh
// constants for the adc state register bank: addresses, fields, defaults
// assumes inclusion by the register bank and its self-checking bench
`ifndef ADSR_CONSTS_VH
`define ADSR_CONSTS_VH

// register addresses
`define ADSR_ADDR_STATE 8'h00
`define ADSR_ADDR_APIGEN 8'h02
`define ADSR_ADDR_CFGLO 8'h06
`define ADSR_ADDR_CFGHI 8'h07
`define ADSR_ADDR_OPTION 8'h08
`define ADSR_ADDR_PAUSE 8'h09
`define ADSR_ADDR_EDGE 8'h0A
`define ADSR_ADDR_OUTLAST 8'h04

// reset values
`define ADSR_RST_CFGLO 8'hB6
`define ADSR_RST_CFGHI 8'h08
`define ADSR_RST_OPTION 8'h00
`define ADSR_RST_PAUSE 8'h20
`define ADSR_RST_EDGE 8'h01
`define ADSR_RD_WO 8'h00

// state_control fields
`define ADSR_SC_START 7
`define ADSR_SC_PD 6
`define ADSR_SC_FIELD_HI 2
`define ADSR_SC_FIELD_LO 0
`define ADSR_FIELD_CONFIG 3'h2
`define ADSR_FIELD_MEAS 3'h3

// measurement mode field in config_high
`define ADSR_MODE_HI 4
`define ADSR_MODE_LO 3
`define ADSR_MODE_FREE 2'h0
`define ADSR_MODE_CMD 2'h1
`define ADSR_MODE_EXTSTART 2'h2
`define ADSR_MODE_EXTWIN 2'h3

// serial slave address, upper five bits; lower two come from pins
`define ADSR_SLAVE_HI 5'h1D

`endif

// File: adsr_sync.v
// two flip-flop synchroniser for signals from outside the clock domain
// assumes a single clock clk and synchronous active-low reset nrst
`default_nettype none

module adsr_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
  // clock and reset
  input wire clk,
  input wire nrst,
  // asynchronous in, synchronised out
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // first stage feeds only the second stage
  always @(posedge clk) begin
    if (!nrst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // adsr_sync

`default_nettype wire

// File: adsr_bank.v
// adc state register bank: two-wire serial slave, control registers, state machine
// assumes clk at 250 MHz, serial clock far slower, converter logic on clk
//
// Functional notes
// - after reset, configuration state with every control register at default.
// - measurement starts per mode; ready rises at conversion end, not in window mode.
// - writing field 010 returns to configuration and restores register defaults.
// - start bit one begins conversion in free running or command mode.
// - in measurement, field 000 acts as start without changing state.
// - every control register is eight bits, accessed one byte at a time.
// - state_control is write only; reading it returns 00.
// - state_control accepts writes in both states.
// - field 010 configuration, 011 measurement; other codes and bits 5..3 reserved.
// - configuration state allows full bank access and no measurement.
// - measurement only in measurement state; other registers locked then.
// - start bit looked at only in measurement, free running or command mode.
// - power down acts in both states; in measurement only between conversions.
// - reset: start 0, power down on, configuration; return restores start and field.
// - api_generation holds family code high nibble, revision low nibble.
// - mode 00 free running, 01 command, 10 external start, 11 external window.
// - first written byte sets pointer; each data byte stored there, pointer plus one.
`default_nettype none
`include "adsr_consts.vh"

module adsr_bank #(
  // arbitrary identification values
  parameter [3:0] DEVICE_FAMILY_CODE = 4'h5,
  parameter [3:0] REGISTER_SET_REVISION = 4'h1
) (
  // clock and reset
  input wire clk,
  input wire nrst,
  // serial bus pins, data is open drain
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe,
  // slave address straps
  input wire addr_pin1,
  input wire addr_pin0,
  // converter side
  input wire conv_done,
  input wire conv_busy,
  input wire [7:0] meas_rd_data,
  output wire [7:0] meas_rd_addr,
  output wire conv_start,
  output wire meas_state,
  output wire power_down,
  output wire ready,
  // configuration out
  output wire [7:0] config_low,
  output wire [7:0] config_high,
  output wire [7:0] option_settings,
  output wire [7:0] pause_settings,
  output wire [7:0] edge_settings,
  output wire [1:0] meas_mode
);

  // engine states
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RX = 3'h1;
  localparam [2:0] ST_ACK = 3'h2;
  localparam [2:0] ST_TX = 3'h3;
  localparam [2:0] ST_RACK = 3'h4;
  // role of the byte being received
  localparam [1:0] BY_SLAVE = 2'h0;
  localparam [1:0] BY_PTR = 2'h1;
  localparam [1:0] BY_DATA = 2'h2;

  wire scl_s;
  wire sda_s;
  wire [1:0] addr_s;
  reg scl_p_q;
  reg sda_p_q;
  reg [2:0] st_q;
  reg [1:0] by_q;
  reg [3:0] cnt_q;
  reg [7:0] sh_q;
  reg [7:0] tx_q;
  reg [7:0] ptr_q;
  reg rw_q;
  reg oe_q;
  reg wr_q;
  reg [7:0] wr_addr_q;
  reg [7:0] wr_data_q;
  reg meas_q;
  reg pd_q;
  reg start_q;
  reg ready_q;
  reg [7:0] cfg_lo_q;
  reg [7:0] cfg_hi_q;
  reg [7:0] opt_q;
  reg [7:0] pause_q;
  reg [7:0] edge_q;
  reg [7:0] rd_data;

  // serial pins and straps cross into clk through two flops
  adsr_sync #(.WIDTH(2), .RST_VAL(2'h3)) u_sync_bus (
    .clk(clk),
    .nrst(nrst),
    .async_in({scl_i, sda_i}),
    .sync_out({scl_s, sda_s})
  );

  adsr_sync #(.WIDTH(2), .RST_VAL(2'h0)) u_sync_strap (
    .clk(clk),
    .nrst(nrst),
    .async_in({addr_pin1, addr_pin0}),
    .sync_out(addr_s)
  );

  // edge detection on synchronised copies only
  always @(posedge clk) begin
    if (!nrst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  wire bus_start = scl_s & scl_p_q & ~sda_s & sda_p_q;
  wire bus_stop = scl_s & scl_p_q & sda_s & ~sda_p_q;
  wire addr_hit = (sh_q[7:1] == {`ADSR_SLAVE_HI, addr_s});

  // read mux: config view versus measurement view of the address space
  always @* begin
    rd_data = 8'h00;
    if (meas_q) begin
      if (ptr_q <= `ADSR_ADDR_OUTLAST)
        rd_data = meas_rd_data;
    end else begin
      case (ptr_q)
        `ADSR_ADDR_STATE: rd_data = `ADSR_RD_WO;
        `ADSR_ADDR_APIGEN: rd_data = {DEVICE_FAMILY_CODE, REGISTER_SET_REVISION};
        `ADSR_ADDR_CFGLO: rd_data = cfg_lo_q;
        `ADSR_ADDR_CFGHI: rd_data = cfg_hi_q;
        `ADSR_ADDR_OPTION: rd_data = opt_q;
        `ADSR_ADDR_PAUSE: rd_data = pause_q;
        `ADSR_ADDR_EDGE: rd_data = edge_q;
        default: rd_data = 8'h00;
      endcase
    end
  end

  // byte engine: edges of scl drive every step, start and stop override
  always @(posedge clk) begin
    if (!nrst) begin
      st_q <= ST_IDLE;
      by_q <= BY_SLAVE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      oe_q <= 1'b0;
      wr_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      wr_q <= 1'b0;
      if (bus_start) begin
        st_q <= ST_RX;
        by_q <= BY_SLAVE;
        cnt_q <= 4'h0;
        oe_q <= 1'b0;
      end else if (bus_stop) begin
        st_q <= ST_IDLE;
        oe_q <= 1'b0;
      end else begin
        case (st_q)
          ST_RX: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_s};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == 4'h8) begin
              cnt_q <= 4'h0;
              if (by_q == BY_SLAVE) begin
                if (addr_hit) begin
                  rw_q <= sh_q[0];
                  oe_q <= 1'b1;
                  st_q <= ST_ACK;
                end else begin
                  st_q <= ST_IDLE;
                end
              end else if (by_q == BY_PTR) begin
                ptr_q <= sh_q;
                by_q <= BY_DATA;
                oe_q <= 1'b1;
                st_q <= ST_ACK;
              end else begin
                wr_q <= 1'b1;
                wr_addr_q <= ptr_q;
                wr_data_q <= sh_q;
                ptr_q <= ptr_q + 8'h01;
                oe_q <= 1'b1;
                st_q <= ST_ACK;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (rw_q && by_q == BY_SLAVE) begin
                // first read byte goes out right after the address ack
                tx_q <= {rd_data[6:0], 1'b0};
                oe_q <= ~rd_data[7];
                ptr_q <= ptr_q + 8'h01;
                cnt_q <= 4'h0;
                st_q <= ST_TX;
              end else begin
                oe_q <= 1'b0;
                if (by_q == BY_SLAVE)
                  by_q <= BY_PTR;
                st_q <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall) begin
              if (cnt_q == 4'h8) begin
                oe_q <= 1'b0;
                st_q <= ST_RACK;
              end else begin
                oe_q <= ~tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              rw_q <= ~sda_s; // remember master ack
            end else if (scl_fall) begin
              if (rw_q) begin
                tx_q <= {rd_data[6:0], 1'b0};
                oe_q <= ~rd_data[7];
                ptr_q <= ptr_q + 8'h01;
                cnt_q <= 4'h0;
                st_q <= ST_TX;
              end else begin
                st_q <= ST_IDLE;
              end
            end
          end
          default: begin
            oe_q <= 1'b0;
            st_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // decode of a state_control write
  wire [2:0] wr_field = wr_data_q[`ADSR_SC_FIELD_HI:`ADSR_SC_FIELD_LO];
  wire sc_wr = wr_q && (wr_addr_q == `ADSR_ADDR_STATE);
  wire go_meas = sc_wr && (wr_field == `ADSR_FIELD_MEAS);
  wire go_cfg = sc_wr && (wr_field == `ADSR_FIELD_CONFIG);
  wire keep_meas = sc_wr && meas_q && (wr_field[1:0] == 2'h0) && !wr_field[2];
  wire meas_next = go_meas | (meas_q & ~go_cfg);
  wire start_mode = (cfg_hi_q[`ADSR_MODE_HI:`ADSR_MODE_LO] == `ADSR_MODE_FREE) ||
                    (cfg_hi_q[`ADSR_MODE_HI:`ADSR_MODE_LO] == `ADSR_MODE_CMD);
  wire cfg_wr = wr_q && !meas_q;

  // state, start and power down; start cleared on return to configuration, power down as written
  always @(posedge clk) begin
    if (!nrst) begin
      meas_q <= 1'b0;
      start_q <= 1'b0;
      pd_q <= 1'b1;
    end else if (sc_wr) begin
      pd_q <= wr_data_q[`ADSR_SC_PD];
      if (go_cfg && meas_q) begin
        meas_q <= meas_next;
        start_q <= 1'b0;
      end else if (go_meas || keep_meas) begin
        meas_q <= 1'b1;
        start_q <= wr_data_q[`ADSR_SC_START];
      end
    end else begin
      start_q <= 1'b0;
    end
  end

  // start pulse only in measurement and only in free running or command mode
  assign conv_start = start_q & meas_q & start_mode;

  // control registers: writable only in configuration, defaults on return
  always @(posedge clk) begin
    if (!nrst || (go_cfg && meas_q)) begin
      cfg_lo_q <= `ADSR_RST_CFGLO;
      cfg_hi_q <= `ADSR_RST_CFGHI;
      opt_q <= `ADSR_RST_OPTION;
      pause_q <= `ADSR_RST_PAUSE;
      edge_q <= `ADSR_RST_EDGE;
    end else if (cfg_wr) begin
      case (wr_addr_q)
        `ADSR_ADDR_CFGLO: cfg_lo_q <= wr_data_q;
        `ADSR_ADDR_CFGHI: cfg_hi_q <= wr_data_q;
        `ADSR_ADDR_OPTION: opt_q <= wr_data_q;
        `ADSR_ADDR_PAUSE: pause_q <= wr_data_q;
        `ADSR_ADDR_EDGE: edge_q <= wr_data_q;
        default: opt_q <= opt_q;
      endcase
    end
  end

  // ready rises on each finished conversion in measurement except in window mode or when a start pulse comes in the same cycle
  always @(posedge clk) begin
    if (!nrst) begin
      ready_q <= 1'b0;
    end else if (!meas_q || conv_start) begin
      ready_q <= 1'b0;
    end else if (conv_done &&
                 cfg_hi_q[`ADSR_MODE_HI:`ADSR_MODE_LO] != `ADSR_MODE_EXTWIN) begin
      ready_q <= 1'b1;
    end
  end

  // outputs
  assign sda_o = 1'b0;
  assign sda_oe = oe_q;
  assign meas_rd_addr = ptr_q;
  assign meas_state = meas_q;
  // power down waits for the pause between conversions while measuring
  assign power_down = pd_q & (~meas_q | ~conv_busy);
  assign ready = ready_q;
  assign config_low = cfg_lo_q;
  assign config_high = cfg_hi_q;
  assign option_settings = opt_q;
  assign pause_settings = pause_q;
  assign edge_settings = edge_q;
  assign meas_mode = cfg_hi_q[`ADSR_MODE_HI:`ADSR_MODE_LO];

  // limitation: measurement reads do not wrap the pointer back to 00 after
  // the last output byte; a longer burst returns zeros instead

endmodule // adsr_bank

`default_nettype wire

// File: adsr_bank_chk.sv
// port checker for the adc state register bank: state, ready and defaults
// assumes a bind to adsr_bank, clk domain with synchronous active-low nrst
`default_nettype none

module adsr_bank_chk (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // converter side
  input wire logic conv_done,
  input wire logic conv_busy,
  input wire logic conv_start,
  input wire logic meas_state,
  input wire logic power_down,
  input wire logic ready,
  // configuration out
  input wire logic [7:0] config_low,
  input wire logic [7:0] config_high,
  input wire logic [1:0] meas_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // reset is synchronous, so it is checked while it is still applied
  a_reset_dflt: assert property (disable iff (1'b0) !nrst |=>
    !meas_state && power_down && !ready && config_low == 8'hB6 && config_high == 8'h08)
    else $error("reset values wrong");
  a_start_meas: assert property (conv_start |-> meas_state)
    else $error("start pulse outside measurement");
  a_ready_cause: assert property ($rose(ready) |-> $past(conv_done) && meas_mode != 2'h3)
    else $error("ready rose without a finished conversion");
  a_ready_set: assert property (conv_done && meas_state && !conv_start
    && meas_mode != 2'h3 |=> ready)
    else $error("ready missed a finished conversion");
  a_ready_exit: assert property ($fell(meas_state) |=> !ready)
    else $error("ready kept after leaving measurement");
  a_pd_busy: assert property (meas_state && conv_busy |-> !power_down)
    else $error("power down during a conversion");
  a_exit_dflt: assert property ($fell(meas_state) |->
    config_low == 8'hB6 && config_high == 8'h08)
    else $error("defaults not restored on return");
  a_cfg_locked: assert property (meas_state && $past(meas_state) |->
    $stable(config_low) && $stable(config_high))
    else $error("configuration changed in measurement");
  a_mode_field: assert property (meas_mode == config_high[4:3])
    else $error("mode output differs from its field");

  // main scenarios reached
  c_start: cover property (conv_start);
  c_ready: cover property ($rose(ready));
  c_exit: cover property ($fell(meas_state));
endmodule // adsr_bank_chk

`default_nettype wire

// File: adsr_master.sv
// two-wire serial bus master model, one bit every 20 clk (80 ns)
// assumes an open-drain data line with pull-up resolved by the bench
`default_nettype none

module adsr_master (
  // clock and resolved data line
  input wire logic clk,
  input wire logic sda,
  // driven pins; m_low high pulls data low
  output var logic scl,
  output var logic m_low
);
  timeunit 1ns;
  timeprecision 1ns;

  // the serial clock idles high, standing still between frames
  initial begin
    scl = 1'b1;
    m_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // data changes mid low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    tick(5);
    m_low = !b;
    tick(5);
    scl = 1'b1;
    tick(5);
    r = sda;
    tick(5);
    scl = 1'b0;
  endtask

  // start and repeated start share one shape
  task automatic start;
    tick(5);
    m_low = 1'b0;
    tick(5);
    scl = 1'b1;
    tick(5);
    m_low = 1'b1;
    tick(5);
    scl = 1'b0;
  endtask

  task automatic stop;
    tick(5);
    m_low = 1'b1;
    tick(5);
    scl = 1'b1;
    tick(5);
    m_low = 1'b0;
    tick(5);
  endtask

  // msb first, ninth bit released for the acknowledge
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask

  // last byte answered with a not-acknowledge before stop
  task automatic rbyte(output logic [7:0] b, input logic last);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(last, r);
  endtask
endmodule // adsr_master

`default_nettype wire

// File: adsr_bank_test.sv
// self-checking bench for the adc state register bank
// assumes adsr_master and adsr_bank_chk are compiled before this file
`default_nettype none
`include "adsr_consts.vh"

module adsr_bank_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, nrst = 0, conv_done = 0, conv_busy = 0, a1 = 0, a0 = 0;
  logic scl, m_low, sda_o, sda_oe, conv_start, meas_state, power_down, ready;
  logic [7:0] meas_rd_addr, cl, ch, opt, pau, edg, rb [0:15], mdl [0:10];
  logic [7:0] d [$];
  logic [1:0] meas_mode;
  logic [6:0] sa, own;
  integer seed = 32'h6FBD, mismatches = 0, checks = 0, starts = 0, n;
  wire sda = !(m_low | (sda_oe & !sda_o)); // pull-up on the data line
  wire [7:0] meas_rd_data = meas_rd_addr ^ 8'hA5; // output registers

  always #2 clk = ~clk;
  always @(posedge clk) if (conv_start === 1'b1) starts <= starts + 1;
  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    final_report();
  end

  adsr_bank adsr_bank_inst (.clk(clk), .nrst(nrst), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .addr_pin1(a1), .addr_pin0(a0),
    .conv_done(conv_done), .conv_busy(conv_busy), .meas_rd_data(meas_rd_data),
    .meas_rd_addr(meas_rd_addr), .conv_start(conv_start), .meas_state(meas_state),
    .power_down(power_down), .ready(ready), .config_low(cl), .config_high(ch),
    .option_settings(opt), .pause_settings(pau), .edge_settings(edg),
    .meas_mode(meas_mode));
  adsr_master adsr_master_inst (.clk(clk), .sda(sda), .scl(scl), .m_low(m_low));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    if (mismatches == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] q [$]);
    logic a;
    adsr_master_inst.start();
    adsr_master_inst.wbyte({sa, 1'b0}, a);
    chk({7'h0, a}, {7'h0, sa == own});
    adsr_master_inst.wbyte(p, a);
    foreach (q[i]) adsr_master_inst.wbyte(q[i], a);
    adsr_master_inst.stop();
  endtask

  task automatic rd(input logic [7:0] p, input int k);
    logic a;
    adsr_master_inst.start();
    adsr_master_inst.wbyte({sa, 1'b0}, a);
    adsr_master_inst.wbyte(p, a);
    adsr_master_inst.start();
    adsr_master_inst.wbyte({sa, 1'b1}, a);
    for (int i = 0; i < k; i++) adsr_master_inst.rbyte(rb[i], i == k - 1);
    adsr_master_inst.stop();
  endtask

  // configuration-state view of the bank
  function automatic logic [7:0] exp_cfg(input int a);
    if (a == 2) return 8'h51;
    if (a >= 6) return mdl[a];
    return `ADSR_RD_WO;
  endfunction

  task automatic dflt;
    mdl[6] = `ADSR_RST_CFGLO;
    mdl[7] = `ADSR_RST_CFGHI;
    mdl[8] = `ADSR_RST_OPTION;
    mdl[9] = `ADSR_RST_PAUSE;
    mdl[10] = `ADSR_RST_EDGE;
  endtask

  task automatic cmp_all;
    rd(8'h00, 11);
    for (int i = 0; i < 11; i++) chk(rb[i], exp_cfg(i));
    // the register outputs must agree with what the bus reads back
    chk(cl, mdl[6]);
    chk(ch, mdl[7]);
    chk(opt, mdl[8]);
    chk(pau, mdl[9]);
    chk(edg, mdl[10]);
  endtask

  // ready is only looked at once the pulse has had two edges to land
  task automatic done_pulse;
    @(negedge clk) conv_done = 1'b1;
    @(negedge clk) conv_done = 1'b0;
    @(negedge clk);
  endtask

  initial begin
    {a1, a0} = 2'($random(seed));
    own = {`ADSR_SLAVE_HI, a1, a0};
    sa = own;
    dflt();
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    repeat (5) @(negedge clk);
    chk({6'h0, meas_state, power_down}, 8'h01);
    cmp_all();
    // random burst over 01..0A; only the read-write places keep it
    for (int i = 1; i < 11; i++) d.push_back(8'($random(seed)));
    wr(8'h01, d);
    for (int i = 6; i < 11; i++) mdl[i] = d[i - 1];
    cmp_all();
    // another slave address is not answered and changes nothing
    sa = own ^ 7'h01;
    wr(8'h06, '{8'h00});
    sa = own;
    wr(8'h00, '{8'hC7});
    wr(8'h00, '{8'hC1});
    chk({7'h0, meas_state}, 8'h00);
    cmp_all();
    // every measurement mode: enter with start, finish (skipped in free running), leave
    for (int m = 0; m < 4; m++) begin
      wr(8'h07, '{8'(m << 3)});
      n = starts;
      wr(8'h00, '{8'h83});
      chk({6'h0, meas_mode}, 8'(m));
      chk({meas_state, power_down, 6'(starts - n)}, {2'h2, 6'(m < 2)});
      wr(8'h06, '{~mdl[6]});
      chk(cl, mdl[6]);
      if (m != 0) begin
        done_pulse();
        chk({7'h0, ready}, {7'h0, m != 3});
      end
      n = starts;
      conv_busy = 1'b1;
      wr(8'h00, '{8'hC0});
      chk({meas_state, power_down, 6'(starts - n)}, {2'h2, 6'(m < 2)});
      // external start mode gets no start pulse here, so its ready stays up
      chk({7'h0, ready}, {7'h0, m == 2});
      @(negedge clk) conv_busy = 1'b0;
      @(negedge clk);
      chk({7'h0, power_down}, 8'h01);
      rd(8'h00, 3);
      for (int i = 0; i < 3; i++) chk(rb[i], 8'(i) ^ 8'hA5);
      wr(8'h00, '{8'h42});
      chk({meas_state, power_down, ready, 5'h0}, 8'h40);
      // leaving measurement puts every control register back to its default
      dflt();
      cmp_all();
    end
    final_report();
  end
endmodule // adsr_bank_test

bind adsr_bank adsr_bank_chk adsr_bank_chk_inst (.clk(clk), .nrst(nrst),
  .conv_done(conv_done), .conv_busy(conv_busy), .conv_start(conv_start),
  .meas_state(meas_state), .power_down(power_down), .ready(ready),
  .config_low(config_low), .config_high(config_high), .meas_mode(meas_mode));

`default_nettype wire
